// ### verilog/cpsr_setpoint_regs.sv
// Set-point command register bank of an isolated power converter.
`timescale 1ns/1ps

// Summary of operation
// - Slew setting in V/ms limits ramp of the output target.
// - No output adjustment applied while current sharing is active.
// - Droop coefficient word, mV/A, read and write.
// - Maximum duty cycle word, linear11 percent, read and write.
// - Switching frequency word, linear11 kHz, read and write.
// - Switching frequency write refused while the output is enabled.
// - Input reaching turn-on threshold starts operation, raises power good.
// - Input reaching turn-off threshold stops operation, drops power good.
// - Phase_stagger_config group identifier held in bits 11 to 8.
// - Phase_stagger_config participant count held in bits 7 to 4.
// - Phase_stagger_config position index held in bits 3 to 0.
// - Index zero drives sync pulse; others follow incoming pulse.
// - Over-voltage limit word; checking starts only after initialization.
// - Output above limit pulls alert low while fault persists.
// - Unsigned linear16 means mantissa times two to minus twelve.
module cpsr_setpoint_regs #(
	parameter int TICK_CYCLES = cpsr_pkg::RAMP_TICK_CYCLES
) (
	input wire logic core_clk,
	input wire logic reset,
	// Command port (decoded command layer of the management bus)
	input wire logic cmd_valid,
	input wire logic cmd_write,
	input wire logic [7:0] cmd_code,
	input wire logic [15:0] cmd_wdata,
	output logic rsp_valid,
	output logic rsp_error,
	output logic [15:0] rsp_rdata,
	// Converter state
	input wire logic init_done,
	input wire logic output_enabled,
	input wire logic share_active,
	input wire logic [15:0] vin_meas,
	input wire logic [15:0] vout_meas,
	input wire logic [15:0] vout_target,
	output logic [15:0] vout_ramped,
	output logic [15:0] droop_coeff,
	output logic [15:0] duty_limit,
	output logic [15:0] fsw_setting,
	output logic device_run,
	output logic power_good,
	// Phase_stagger_config
	output logic [3:0] stagger_group,
	output logic [3:0] stagger_count,
	output logic [3:0] stagger_order,
	input wire logic local_cycle_start,
	input wire logic sync_in,
	output logic sync_out,
	output logic sync_oe_n,
	output logic phase_ref,
	// Alert (open drain) and protection request
	output logic fault_alert_line_out,
	output logic fault_alert_line_oe_n,
	output logic ov_fault
);

	localparam int TICK_W = $clog2(TICK_CYCLES + 1);

	generate
		if (TICK_CYCLES < 2) begin : g_bad_tick
			$error("cpsr_setpoint_regs: TICK_CYCLES must be at least 2");
		end
	endgenerate

	// ---------------------------------------------------------------
	// Declarations
	// ---------------------------------------------------------------
	logic [15:0] regs [cpsr_pkg::NUM_REGS];
	logic [2:0] cmd_idx;
	logic cmd_known;
	logic wr_refused;
	logic wr_ok;
	logic [TICK_W-1:0] tick_cnt;
	logic ms_tick;
	logic [cpsr_pkg::FIX_W-1:0] vin_fx;
	logic [cpsr_pkg::FIX_W-1:0] on_fx;
	logic [cpsr_pkg::FIX_W-1:0] off_fx;
	logic ov_detect;
	logic [15:0] ramp_level;

	// ---------------------------------------------------------------
	// Command decode
	// ---------------------------------------------------------------
	// Map command code onto a bank slot
	always_comb begin
		cmd_known = 1'b1;
		case (cmd_code)
			cpsr_pkg::CMD_SLEW: cmd_idx = cpsr_pkg::IDX_SLEW;
			cpsr_pkg::CMD_DROOP: cmd_idx = cpsr_pkg::IDX_DROOP;
			cpsr_pkg::CMD_DUTY: cmd_idx = cpsr_pkg::IDX_DUTY;
			cpsr_pkg::CMD_FSW: cmd_idx = cpsr_pkg::IDX_FSW;
			cpsr_pkg::CMD_INPUT_TURN_ON_THRESHOLD: cmd_idx = cpsr_pkg::IDX_INPUT_TURN_ON_THRESHOLD;
			cpsr_pkg::CMD_INPUT_TURN_OFF_THRESHOLD: cmd_idx = cpsr_pkg::IDX_INPUT_TURN_OFF_THRESHOLD;
			cpsr_pkg::CMD_STAGGER: cmd_idx = cpsr_pkg::IDX_STAGGER;
			cpsr_pkg::CMD_OV_LIMIT: cmd_idx = cpsr_pkg::IDX_OV_LIMIT;
			default: begin
				cmd_idx = cpsr_pkg::IDX_SLEW;
				cmd_known = 1'b0;
			end
		endcase
	end

	assign wr_refused = cmd_write && cmd_code == cpsr_pkg::CMD_FSW
		&& output_enabled;
	assign wr_ok = cmd_valid && cmd_write && cmd_known && !wr_refused;

	// ---------------------------------------------------------------
	// Register bank
	// ---------------------------------------------------------------
	// full-word storage for every setting
	always_ff @(posedge core_clk) begin
		if (reset) begin
			regs[cpsr_pkg::IDX_SLEW] <= cpsr_pkg::RST_SLEW;
			regs[cpsr_pkg::IDX_DROOP] <= cpsr_pkg::RST_DROOP;
			regs[cpsr_pkg::IDX_DUTY] <= cpsr_pkg::RST_DUTY;
			regs[cpsr_pkg::IDX_FSW] <= cpsr_pkg::RST_FSW;
			regs[cpsr_pkg::IDX_INPUT_TURN_ON_THRESHOLD] <= cpsr_pkg::RST_INPUT_TURN_ON_THRESHOLD;
			regs[cpsr_pkg::IDX_INPUT_TURN_OFF_THRESHOLD] <= cpsr_pkg::RST_INPUT_TURN_OFF_THRESHOLD;
			regs[cpsr_pkg::IDX_STAGGER] <= cpsr_pkg::RST_STAGGER;
			regs[cpsr_pkg::IDX_OV_LIMIT] <= cpsr_pkg::RST_OV_LIMIT;
		end else if (wr_ok) begin
			regs[cmd_idx] <= cmd_wdata;
		end
	end

	// Answer one cycle after each command
	always_ff @(posedge core_clk) begin
		if (reset) begin
			rsp_valid <= 1'b0;
			rsp_error <= 1'b0;
			rsp_rdata <= 16'h0000;
		end else begin
			rsp_valid <= cmd_valid;
			rsp_error <= cmd_valid && (!cmd_known || wr_refused);
			// Reads of unknown codes return zero
			if (cmd_valid && !cmd_write && cmd_known) begin
				rsp_rdata <= regs[cmd_idx];
			end else if (cmd_valid) begin
				rsp_rdata <= 16'h0000;
			end
		end
	end

	// ---------------------------------------------------------------
	// Settings presented to the power stage
	// ---------------------------------------------------------------
	// duty limit forwarded
	always_ff @(posedge core_clk) begin
		if (reset) begin
			droop_coeff <= cpsr_pkg::RST_DROOP;
			duty_limit <= cpsr_pkg::RST_DUTY;
			fsw_setting <= cpsr_pkg::RST_FSW;
		end else begin
			droop_coeff <= regs[cpsr_pkg::IDX_DROOP];
			duty_limit <= regs[cpsr_pkg::IDX_DUTY];
			fsw_setting <= regs[cpsr_pkg::IDX_FSW];
		end
	end

	// ---------------------------------------------------------------
	// Slew ramp
	// ---------------------------------------------------------------
	// Millisecond tick; slew and target share the volt scale,
	// so the slew word is directly the step per tick.
	always_ff @(posedge core_clk) begin
		if (reset) begin
			tick_cnt <= '0;
			ms_tick <= 1'b0;
		end else if (tick_cnt == TICK_W'(TICK_CYCLES - 1)) begin
			tick_cnt <= '0;
			ms_tick <= 1'b1;
		end else begin
			tick_cnt <= tick_cnt + 1'b1;
			ms_tick <= 1'b0;
		end
	end

	cpsr_slew_ramp u_ramp (
		.core_clk(core_clk),
		.reset(reset),
		.tick(ms_tick),
		.hold(share_active),
		.target(vout_target),
		.step(regs[cpsr_pkg::IDX_SLEW]),
		.level(ramp_level)
	);

	always_ff @(posedge core_clk) begin
		if (reset) begin
			vout_ramped <= 16'h0000;
		end else begin
			vout_ramped <= ramp_level;
		end
	end

	// ---------------------------------------------------------------
	// Input turn-on / turn-off
	// ---------------------------------------------------------------
	cpsr_lin11_decode u_vin_dec (
		.core_clk(core_clk),
		.reset(reset),
		.lin11(vin_meas),
		.fixed_val(vin_fx)
	);

	cpsr_lin11_decode u_on_dec (
		.core_clk(core_clk),
		.reset(reset),
		.lin11(regs[cpsr_pkg::IDX_INPUT_TURN_ON_THRESHOLD]),
		.fixed_val(on_fx)
	);

	cpsr_lin11_decode u_off_dec (
		.core_clk(core_clk),
		.reset(reset),
		.lin11(regs[cpsr_pkg::IDX_INPUT_TURN_OFF_THRESHOLD]),
		.fixed_val(off_fx)
	);

	// start and power good
	// Hysteresis comes from the two thresholds; a stopped unit only
	// looks at turn-on, a running one only at turn-off.
	always_ff @(posedge core_clk) begin
		if (reset) begin
			device_run <= 1'b0;
			power_good <= 1'b0;
		end else if (!device_run && vin_fx >= on_fx) begin
			device_run <= 1'b1;
			power_good <= 1'b1;
		end else if (device_run && vin_fx <= off_fx) begin
			device_run <= 1'b0;
			power_good <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// Phase_stagger_config
	// ---------------------------------------------------------------
	// group field
	always_ff @(posedge core_clk) begin
		if (reset) begin
			stagger_group <= 4'h0;
			stagger_count <= 4'h0;
			stagger_order <= 4'h0;
		end else begin
			stagger_group <= regs[cpsr_pkg::IDX_STAGGER]
				[cpsr_pkg::GROUP_MSB:cpsr_pkg::GROUP_LSB];
			stagger_count <= regs[cpsr_pkg::IDX_STAGGER]
				[cpsr_pkg::COUNT_MSB:cpsr_pkg::COUNT_LSB];
			stagger_order <= regs[cpsr_pkg::IDX_STAGGER]
				[cpsr_pkg::ORDER_MSB:cpsr_pkg::ORDER_LSB];
		end
	end

	// master drives, followers listen
	// Followers release the pin so several units can share one wire.
	always_ff @(posedge core_clk) begin
		if (reset) begin
			sync_out <= 1'b0;
			sync_oe_n <= 1'b1;
			phase_ref <= 1'b0;
		end else if (stagger_order == cpsr_pkg::ORDER_MASTER) begin
			sync_out <= local_cycle_start;
			sync_oe_n <= 1'b0;
			phase_ref <= local_cycle_start;
		end else begin
			sync_out <= 1'b0;
			sync_oe_n <= 1'b1;
			phase_ref <= sync_in;
		end
	end

	// ---------------------------------------------------------------
	// Over-voltage monitor
	// ---------------------------------------------------------------
	// compare only after init
	// both sides share the minus-twelve scale, compare raw
	assign ov_detect = init_done
		&& vout_meas > regs[cpsr_pkg::IDX_OV_LIMIT];

	always_ff @(posedge core_clk) begin
		if (reset) begin
			fault_alert_line_out <= 1'b0;
			fault_alert_line_oe_n <= 1'b1;
			ov_fault <= 1'b0;
		end else begin
			fault_alert_line_out <= 1'b0;
			fault_alert_line_oe_n <= !ov_detect;
			ov_fault <= ov_detect;
		end
	end

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	a_freq_refused: assert property (@(posedge core_clk) disable iff (reset)
		cmd_valid && cmd_write && cmd_code == cpsr_pkg::CMD_FSW
		&& output_enabled
		|=> rsp_error && $stable(regs[cpsr_pkg::IDX_FSW])
		##1 $stable(fsw_setting))
		else $error("frequency write accepted while output on");

	a_write_readback: assert property (@(posedge core_clk) disable iff (reset)
		cmd_valid && cmd_write && cmd_code == cpsr_pkg::CMD_DROOP
		##1 cmd_valid && !cmd_write && cmd_code == cpsr_pkg::CMD_DROOP
		|=> rsp_rdata == $past(cmd_wdata, 2))
		else $error("droop read back differs from write");

	// Same check with one idle cycle between write and read
	a_gap_readback: assert property (@(posedge core_clk) disable iff (reset)
		cmd_valid && cmd_write && cmd_code == cpsr_pkg::CMD_DROOP
		##1 !cmd_valid
		##1 cmd_valid && !cmd_write && cmd_code == cpsr_pkg::CMD_DROOP
		|=> rsp_rdata == $past(cmd_wdata, 3))
		else $error("droop read back after gap differs from write");

	a_alert_low: assert property (@(posedge core_clk) disable iff (reset)
		ov_detect |=> !fault_alert_line_oe_n && !fault_alert_line_out
		&& ov_fault)
		else $error("alert not driven low on over-voltage");

	a_alert_init: assert property (@(posedge core_clk) disable iff (reset)
		!init_done |=> fault_alert_line_oe_n && !ov_fault)
		else $error("over-voltage reported before init");

	a_run_on: assert property (@(posedge core_clk) disable iff (reset)
		!device_run && vin_fx >= on_fx |=> device_run && power_good)
		else $error("unit failed to start at turn-on threshold");

	a_run_off: assert property (@(posedge core_clk) disable iff (reset)
		device_run && vin_fx <= off_fx |=> !device_run && !power_good)
		else $error("unit failed to stop at turn-off threshold");

	a_sync_master: assert property (@(posedge core_clk) disable iff (reset)
		stagger_order == cpsr_pkg::ORDER_MASTER
		|=> !sync_oe_n && sync_out == $past(local_cycle_start))
		else $error("index zero not driving sync");

	a_sync_follow: assert property (@(posedge core_clk) disable iff (reset)
		stagger_order != cpsr_pkg::ORDER_MASTER
		|=> sync_oe_n && phase_ref == $past(sync_in))
		else $error("follower not tracking incoming sync");

	a_order_field: assert property (@(posedge core_clk) disable iff (reset)
		wr_ok && cmd_code == cpsr_pkg::CMD_STAGGER |-> ##2
		stagger_group == $past(cmd_wdata[11:8], 2)
		&& stagger_count == $past(cmd_wdata[7:4], 2)
		&& stagger_order == $past(cmd_wdata[3:0], 2))
		else $error("phase_stagger_config fields misplaced");

endmodule : cpsr_setpoint_regs

// ### common/cpsr_pkg.sv
// Constants shared by the converter set-point register bank.
package cpsr_pkg;

	// ---------------------------------------------------------------
	// Command codes
	// ---------------------------------------------------------------
	localparam logic [7:0] CMD_SLEW = 8'h27;
	localparam logic [7:0] CMD_DROOP = 8'h28;
	localparam logic [7:0] CMD_DUTY = 8'h32;
	localparam logic [7:0] CMD_FSW = 8'h33;
	localparam logic [7:0] CMD_INPUT_TURN_ON_THRESHOLD = 8'h35;
	localparam logic [7:0] CMD_INPUT_TURN_OFF_THRESHOLD = 8'h36;
	localparam logic [7:0] CMD_STAGGER = 8'h37;
	localparam logic [7:0] CMD_OV_LIMIT = 8'h40;

	// ---------------------------------------------------------------
	// Register slots inside the bank
	// ---------------------------------------------------------------
	localparam int NUM_REGS = 8;
	localparam logic [2:0] IDX_SLEW = 3'h0;
	localparam logic [2:0] IDX_DROOP = 3'h1;
	localparam logic [2:0] IDX_DUTY = 3'h2;
	localparam logic [2:0] IDX_FSW = 3'h3;
	localparam logic [2:0] IDX_INPUT_TURN_ON_THRESHOLD = 3'h4;
	localparam logic [2:0] IDX_INPUT_TURN_OFF_THRESHOLD = 3'h5;
	localparam logic [2:0] IDX_STAGGER = 3'h6;
	localparam logic [2:0] IDX_OV_LIMIT = 3'h7;

	// Reset values (plain defaults)
	localparam logic [15:0] RST_SLEW = 16'h0000;
	localparam logic [15:0] RST_DROOP = 16'h0000;
	localparam logic [15:0] RST_DUTY = 16'h0000;
	localparam logic [15:0] RST_FSW = 16'h0000;
	localparam logic [15:0] RST_INPUT_TURN_ON_THRESHOLD = 16'h0000;
	localparam logic [15:0] RST_INPUT_TURN_OFF_THRESHOLD = 16'h0000;
	localparam logic [15:0] RST_STAGGER = 16'h0000;
	localparam logic [15:0] RST_OV_LIMIT = 16'hffff;

	// ---------------------------------------------------------------
	// Field layouts
	// ---------------------------------------------------------------
	localparam int GROUP_MSB = 11;
	localparam int GROUP_LSB = 8;
	localparam int COUNT_MSB = 7;
	localparam int COUNT_LSB = 4;
	localparam int ORDER_MSB = 3;
	localparam int ORDER_LSB = 0;
	localparam logic [3:0] ORDER_MASTER = 4'h0;
	localparam int L11_MANT_MSB = 10;
	localparam int L11_EXP_MSB = 15;
	localparam int L11_EXP_LSB = 11;
	localparam int UL16_EXP = -12;
	localparam int FIX_FRAC = 8;
	localparam int FIX_W = 24;

	// ---------------------------------------------------------------
	// Timing
	// ---------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 40;
	localparam int RAMP_TICK_NS = 1000000;
	localparam int RAMP_TICK_CYCLES = RAMP_TICK_NS / CLK_PERIOD_NS;

endpackage : cpsr_pkg

// ### verilog/cpsr_lin11_decode.sv
// Linear11 to unsigned fixed-point converter with registered result.
`timescale 1ns/1ps

module cpsr_lin11_decode #(
	parameter int OUT_W = cpsr_pkg::FIX_W,
	parameter int FRAC = cpsr_pkg::FIX_FRAC
) (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic [15:0] lin11,
	output logic [OUT_W-1:0] fixed_val
);

	generate
		if (OUT_W < FRAC + 16 || OUT_W > 48) begin : g_bad_width
			$error("cpsr_lin11_decode: OUT_W out of range");
		end
	endgenerate

	logic [OUT_W-1:0] next_fixed_val;

	// ---------------------------------------------------------------
	// Decode
	// ---------------------------------------------------------------
	// linear11 interpretation
	always_comb begin
		logic signed [10:0] mant;
		logic signed [4:0] expo;
		int sh;
		logic [63:0] wide;
		mant = lin11[cpsr_pkg::L11_MANT_MSB:0];
		expo = lin11[cpsr_pkg::L11_EXP_MSB:cpsr_pkg::L11_EXP_LSB];
		sh = int'(expo) + FRAC;
		wide = {54'h0, lin11[cpsr_pkg::L11_MANT_MSB-1:0]};
		if (sh >= 0) begin
			wide = wide << sh;
		end else begin
			wide = wide >> (-sh);
		end
		// Negative values have no meaning for thresholds: floor at zero
		if (mant < 0) begin
			next_fixed_val = '0;
		end else if (wide[63:OUT_W] != '0) begin
			next_fixed_val = '1;
		end else begin
			next_fixed_val = wide[OUT_W-1:0];
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			fixed_val <= '0;
		end else begin
			fixed_val <= next_fixed_val;
		end
	end

endmodule : cpsr_lin11_decode

// ### verilog/cpsr_slew_ramp.sv
// Output target ramp limited by a per-tick slew step.
`timescale 1ns/1ps

module cpsr_slew_ramp (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic tick,
	input wire logic hold,
	input wire logic [15:0] target,
	input wire logic [15:0] step,
	output logic [15:0] level
);

	logic [15:0] diff_up;
	logic [15:0] diff_dn;

	assign diff_up = target - level;
	assign diff_dn = level - target;

	// ---------------------------------------------------------------
	// Ramp
	// ---------------------------------------------------------------
	// slew limited ramp
	always_ff @(posedge core_clk) begin
		if (reset) begin
			level <= 16'h0000;
		end else if (tick && !hold) begin
			// Zero step means no limit: jump straight to target
			if (step == 16'h0000) begin
				level <= target;
			end else if (level < target) begin
				level <= (diff_up > step) ? level + step : target;
			end else if (level > target) begin
				level <= (diff_dn > step) ? level - step : target;
			end
		end
	end

	a_ramp_hold: assert property (@(posedge core_clk) disable iff (reset)
		hold |=> $stable(level))
		else $error("ramp moved while sharing active");

	a_ramp_step: assert property (@(posedge core_clk) disable iff (reset)
		(tick && !hold && step != 16'h0000 && level < target)
		|=> (level - $past(level)) <= $past(step))
		else $error("ramp step above slew setting");

endmodule : cpsr_slew_ramp

// ### testbench/cpsr_host_model.sv
// Host model that issues whole-word commands to the set-point bank.
`timescale 1ns/1ps

module cpsr_host_model (
	input wire logic core_clk,
	output logic cmd_valid,
	output logic cmd_write,
	output logic [7:0] cmd_code,
	output logic [15:0] cmd_wdata,
	input wire logic rsp_valid,
	input wire logic rsp_error,
	input wire logic [15:0] rsp_rdata
);
	// Idle command port from time zero
	initial begin
		cmd_valid = 1'b0;
		cmd_write = 1'b0;
		cmd_code = 8'h00;
		cmd_wdata = 16'h0000;
	end

	// caller restraint
	// Frequency writes with the output on are only made when a test wants
	// the refusal; the caller owns output and sharing state.
	// unique index
	// Single device on the bus, so any group word keeps its index unique.
	task automatic xfer(input logic wr, input logic [7:0] code,
		input logic [15:0] wdata, output logic rv, output logic er,
		output logic [15:0] rd);
		@(negedge core_clk);
		cmd_valid = 1'b1;
		cmd_write = wr;
		cmd_code = code;
		cmd_wdata = wdata;
		@(negedge core_clk);
		cmd_valid = 1'b0;
		// Released lines carry the inverse, not a stale copy
		cmd_code = ~code;
		cmd_wdata = ~wdata;
		rv = rsp_valid;
		er = rsp_error;
		rd = rsp_rdata;
	endtask : xfer
endmodule : cpsr_host_model

// ### testbench/tb.sv
// Self-checking bench for the converter set-point register bank.
`timescale 1ns/1ps

module tb;
	logic core_clk, reset, init_done, output_enabled, share_active;
	logic [15:0] vin_meas, vout_meas, vout_target, vout_ramped;
	logic [15:0] droop_coeff, duty_limit, fsw_setting, rsp_rdata, cmd_wdata;
	logic local_cycle_start, sync_in, sync_out, sync_oe_n, phase_ref;
	logic cmd_valid, cmd_write, rsp_valid, rsp_error, device_run, power_good;
	logic [7:0] cmd_code;
	logic [3:0] stagger_group, stagger_count, stagger_order;
	logic fault_alert_line_out, fault_alert_line_oe_n, ov_fault;
	int errors = 0;
	int check_count = 0;
	logic [7:0] codes [8] = '{cpsr_pkg::CMD_SLEW, cpsr_pkg::CMD_DROOP,
		cpsr_pkg::CMD_DUTY, cpsr_pkg::CMD_FSW, cpsr_pkg::CMD_INPUT_TURN_ON_THRESHOLD,
		cpsr_pkg::CMD_INPUT_TURN_OFF_THRESHOLD, cpsr_pkg::CMD_STAGGER, cpsr_pkg::CMD_OV_LIMIT};
	logic [15:0] vals [8] = '{16'h0002, 16'h1234, 16'hd864, 16'h0a5a,
		16'h0030, 16'h0028, 16'h0a31, 16'h4000};

	cpsr_host_model cpsr_host_model_i (.core_clk(core_clk),
		.cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_code(cmd_code),
		.cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid),
		.rsp_error(rsp_error), .rsp_rdata(rsp_rdata));

	// Short ramp tick keeps the slew test brief
	cpsr_setpoint_regs #(.TICK_CYCLES(4)) cpsr_setpoint_regs_i (
		.core_clk(core_clk), .reset(reset), .cmd_valid(cmd_valid),
		.cmd_write(cmd_write), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata),
		.rsp_valid(rsp_valid), .rsp_error(rsp_error), .rsp_rdata(rsp_rdata),
		.init_done(init_done), .output_enabled(output_enabled),
		.share_active(share_active), .vin_meas(vin_meas),
		.vout_meas(vout_meas), .vout_target(vout_target),
		.vout_ramped(vout_ramped), .droop_coeff(droop_coeff),
		.duty_limit(duty_limit), .fsw_setting(fsw_setting),
		.device_run(device_run), .power_good(power_good),
		.stagger_group(stagger_group), .stagger_count(stagger_count),
		.stagger_order(stagger_order),
		.local_cycle_start(local_cycle_start), .sync_in(sync_in),
		.sync_out(sync_out), .sync_oe_n(sync_oe_n), .phase_ref(phase_ref),
		.fault_alert_line_out(fault_alert_line_out),
		.fault_alert_line_oe_n(fault_alert_line_oe_n), .ov_fault(ov_fault));

	// 25 MHz clock
	initial begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end

	task automatic check(input string name, input logic [15:0] seen,
		input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic cyc(input int n);
		repeat (n) @(negedge core_clk);
	endtask : cyc

	// One command; answer must come in the cycle after it is taken
	task automatic cmd(input logic wr, input logic [7:0] code,
		input logic [15:0] wdata, input logic exp_er,
		input logic [15:0] exp_rd);
		logic rv, er;
		logic [15:0] rd;
		cpsr_host_model_i.xfer(wr, code, wdata, rv, er, rd);
		check("rsp_valid", 16'(rv), 16'h0001);
		check("rsp_error", 16'(er), 16'(exp_er));
		if (!wr) check("rsp_rdata", rd, exp_rd);
	endtask : cmd

	task automatic summarize;
		$display("checks %0d mismatches %0d", check_count, errors);
		if (errors == 0 && check_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : summarize

	task automatic test_reset;
		for (int i = 0; i < 8; i++) begin
			cmd(1'b0, codes[i], 16'h0000, 1'b0, (i == 7) ? 16'hffff : 16'h0000);
		end
		cmd(1'b0, 8'h29, 16'h0000, 1'b1, 16'h0000);
		cmd(1'b1, 8'h29, 16'h5555, 1'b1, 16'h0000);
		check("alert_oe_n", 16'(fault_alert_line_oe_n), 16'h0001);
		$display("test reset done");
	endtask : test_reset

	task automatic test_rw;
		for (int i = 0; i < 8; i++) cmd(1'b1, codes[i], vals[i], 1'b0, 16'h0000);
		for (int i = 0; i < 8; i++) cmd(1'b0, codes[i], 16'h0000, 1'b0, vals[i]);
		// Write then read one idle cycle later
		cmd(1'b1, cpsr_pkg::CMD_DROOP, vals[1], 1'b0, 16'h0000);
		cmd(1'b0, cpsr_pkg::CMD_DROOP, 16'h0000, 1'b0, vals[1]);
		check("droop_coeff", droop_coeff, vals[1]);
		check("duty_limit", duty_limit, vals[2]);
		check("fsw_setting", fsw_setting, vals[3]);
		check("group", 16'(stagger_group), 16'h000a);
		check("count", 16'(stagger_count), 16'h0003);
		check("order", 16'(stagger_order), 16'h0001);
		$display("test rw done");
	endtask : test_rw

	task automatic test_fsw_lock;
		output_enabled = 1'b1;
		cmd(1'b1, cpsr_pkg::CMD_FSW, 16'h0b00, 1'b1, 16'h0000);
		cmd(1'b0, cpsr_pkg::CMD_FSW, 16'h0000, 1'b0, vals[3]);
		check("fsw_setting", fsw_setting, vals[3]);
		output_enabled = 1'b0;
		$display("test fsw lock done");
	endtask : test_fsw_lock

	// Linear11 with zero exponent: 47 V, 48 V, 41 V, 40 V
	task automatic test_vin;
		vin_meas = 16'h002f;
		cyc(3);
		check("device_run", 16'(device_run), 16'h0000);
		vin_meas = 16'h0030;
		cyc(3);
		check("device_run", 16'(device_run), 16'h0001);
		check("power_good", 16'(power_good), 16'h0001);
		vin_meas = 16'h0029;
		cyc(3);
		check("power_good", 16'(power_good), 16'h0001);
		vin_meas = 16'h0028;
		cyc(3);
		check("device_run", 16'(device_run), 16'h0000);
		check("power_good", 16'(power_good), 16'h0000);
		$display("test vin done");
	endtask : test_vin

	task automatic test_ov;
		vout_meas = 16'h4001;
		cyc(3);
		check("alert_oe_n", 16'(fault_alert_line_oe_n), 16'h0001);
		init_done = 1'b1;
		cyc(2);
		check("alert_oe_n", 16'(fault_alert_line_oe_n), 16'h0000);
		check("alert_out", 16'(fault_alert_line_out), 16'h0000);
		cyc(5);
		check("ov_fault", 16'(ov_fault), 16'h0001);
		vout_meas = 16'h4000;
		cyc(2);
		check("alert_oe_n", 16'(fault_alert_line_oe_n), 16'h0001);
		check("ov_fault", 16'(ov_fault), 16'h0000);
		$display("test ov done");
	endtask : test_ov

	task automatic test_sync;
		check("sync_oe_n", 16'(sync_oe_n), 16'h0001);
		sync_in = 1'b1;
		cyc(1);
		check("phase_ref", 16'(phase_ref), 16'h0001);
		sync_in = 1'b0;
		local_cycle_start = 1'b1;
		cyc(1);
		check("phase_ref", 16'(phase_ref), 16'h0000);
		local_cycle_start = 1'b0;
		cmd(1'b1, cpsr_pkg::CMD_STAGGER, 16'h0a30, 1'b0, 16'h0000);
		// Order field lands one cycle after the register write
		cyc(1);
		local_cycle_start = 1'b1;
		cyc(1);
		check("sync_oe_n", 16'(sync_oe_n), 16'h0000);
		check("sync_out", 16'(sync_out), 16'h0001);
		local_cycle_start = 1'b0;
		sync_in = 1'b1;
		cyc(1);
		check("phase_ref", 16'(phase_ref), 16'h0000);
		sync_in = 1'b0;
		$display("test sync done");
	endtask : test_sync

	// Slew 2 per tick toward 7; tick every 4 cycles
	task automatic test_ramp;
		int n;
		share_active = 1'b1;
		vout_target = 16'h0007;
		cyc(20);
		check("vout_ramped", vout_ramped, 16'h0000);
		share_active = 1'b0;
		cyc(8);
		check("ramp_limited", 16'(vout_ramped < 16'h0007), 16'h0001);
		check("ramp_moving", 16'(vout_ramped > 16'h0000), 16'h0001);
		n = 0;
		while (vout_ramped !== 16'h0007 && n < 100) begin
			cyc(1);
			n++;
		end
		// Ramp is the last test, so a timeout falls through to the report
		if (n >= 100) begin
			errors++;
		end
		check("vout_ramped", vout_ramped, 16'h0007);
		$display("test ramp done");
	endtask : test_ramp

	// Main sequence
	initial begin
		reset = 1'b1;
		init_done = 1'b0;
		output_enabled = 1'b0;
		share_active = 1'b0;
		vin_meas = 16'h0000;
		vout_meas = 16'h0000;
		vout_target = 16'h0000;
		local_cycle_start = 1'b0;
		sync_in = 1'b0;
		cyc(16);
		reset = 1'b0;
		test_reset();
		test_rw();
		test_fsw_lock();
		test_vin();
		test_ov();
		test_sync();
		test_ramp();
		summarize();
	end
endmodule : tb
